/* File: inc/dims_pkg.sv */
package dims_pkg;
   // =====================================================
   // command pins as sampled at one clock edge
   typedef struct packed {
      logic        cke;
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [2:0]  ba;
      logic [12:0] addr;
   } dims_cmd_t;

   // software timing control
   typedef struct packed {
      logic [3:0] tmrd;
      logic [4:0] trp;
   } dims_ctrl_t;

   typedef enum logic [2:0] {
      DIMS_IDLE = 3'b001,
      DIMS_MRD  = 3'b010,
      DIMS_SREF = 3'b100
   } dims_state_t;

   // =====================================================
   // register byte offsets
   localparam logic [7:0] OFS_MR   = 8'h00;
   localparam logic [7:0] OFS_EMR1 = 8'h04;
   localparam logic [7:0] OFS_EMR2 = 8'h08;
   localparam logic [7:0] OFS_EMR3 = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_BANK = 8'h14;
   localparam logic [7:0] OFS_CTRL = 8'h18;

   // reset values and counts
   localparam logic [4:0] RST_TRP  = 5'h05;
   localparam logic [3:0] RST_TMRD = 4'h2;
   localparam logic [7:0] DLL_LOCK_CLKS = 8'hc8; // 200 clocks

   // field positions
   localparam int MR_BT      = 3;
   localparam int MR_CL_LSB  = 4;
   localparam int MR_TM      = 7;
   localparam int MR_DLLRST  = 8;
   localparam int E1_DLL_DIS = 0;
   localparam int AP_BIT     = 10;
   localparam int ST_ILL     = 0;
   localparam int ST_BADRD   = 1;

   // encodings
   localparam logic [2:0] BL_8      = 3'h3;
   localparam logic [2:0] BA_MR     = 3'h0;
   localparam logic [2:0] BA_EMR1   = 3'h1;
   localparam logic [2:0] BA_EMR2   = 3'h2;
   localparam logic [2:0] BA_EMR3   = 3'h3;
   localparam logic [2:0] OP_ACT    = 3'h3;
   localparam logic [2:0] OP_PRE    = 3'h2;
   localparam logic [2:0] OP_RD     = 3'h5;
   localparam logic [2:0] OP_WR     = 3'h4;
   localparam logic [2:0] OP_REF    = 3'h1;
   localparam logic [2:0] OP_MRS    = 3'h0;
   localparam logic [2:0] BURST4    = 3'h2;
   localparam logic [2:0] BURST8    = 3'h4;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;
endpackage : dims_pkg

/* File: verilog/dims_top.sv */
// Function
// - bursts are fixed at 4 or 8, chosen by mode bits A0-A2
// - activate latches bank and row; read/write take column, and precharge when A10 is set
// - mode write: all strobes low, banks low, all idle, then tMRD
// - A3 is burst type, A4-A6 CAS latency, no half clocks
// - A7 test mode must be low (a set A7 is stored and shown in status, not refused); A8 requests DLL reset
// - register 1 write: BA0 high, all idle, CKE high, tMRD
// - register 1 fields: DLL, drive, latency, ODT, OCD, strobe
// - DLL off on self-refresh entry, back on at exit
`timescale 1ns/1ps
module dims_top (
   input  wire logic        MCLK,      // 250 MHz clock
   input  wire logic        SRST,      // sync reset, active high
   input  wire logic        CKE,       // clock enable pin
   input  wire logic        CS_N,      // chip select pin
   input  wire logic        RAS_N,     // row strobe pin
   input  wire logic        CAS_N,     // column strobe pin
   input  wire logic        WE_N,      // write enable pin
   input  wire logic [2:0]  BA,        // bank pins
   input  wire logic [12:0] ADDR,      // address pins
   input  wire logic [7:0]  AWADDR,    // axi write address
   input  wire logic        AWVALID,   // axi
   output logic             AWREADY,   // axi
   input  wire logic [31:0] WDATA,     // axi
   input  wire logic [3:0]  WSTRB,     // axi
   input  wire logic        WVALID,    // axi
   output logic             WREADY,    // axi
   output logic [1:0]       BRESP,     // axi
   output logic             BVALID,    // axi
   input  wire logic        BREADY,    // axi
   input  wire logic [7:0]  ARADDR,    // axi read address
   input  wire logic        ARVALID,   // axi
   output logic             ARREADY,   // axi
   output logic [31:0]      RDATA,     // axi
   output logic [1:0]       RRESP,     // axi
   output logic             RVALID,    // axi
   input  wire logic        RREADY,    // axi
   output logic             DLL_LOCKED, // dll ready for reads
   output logic             BURST_ACTIVE // burst in progress
);
   // =====================================================
   // functions
   function automatic logic is_op(input dims_pkg::dims_cmd_t c,
                                  input logic [2:0] op);
      is_op = ~c.cs_n && ({c.ras_n, c.cas_n, c.we_n} == op);
   endfunction : is_op

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a <= dims_pkg::OFS_CTRL) && (a[1:0] == 2'h0);
   endfunction : reg_hit

   // =====================================================
   // pin synchroniser, two stages before any logic
   dims_pkg::dims_cmd_t pin_s1_ff;
   dims_pkg::dims_cmd_t c_ff;
   logic                cke_prev_ff;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         pin_s1_ff   <= '0;
         c_ff        <= '0;
         cke_prev_ff <= 1'b0;
      end else begin
         pin_s1_ff   <= {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR};
         c_ff        <= pin_s1_ff;
         cke_prev_ff <= c_ff.cke;
      end
   end

   // =====================================================
   // command decode
   dims_pkg::dims_state_t st_ff;
   dims_pkg::dims_ctrl_t  ctrl_ff;
   logic [7:0]  open_ff;
   logic [12:0] row_ff [8];
   logic [4:0]  pcnt_ff [8];
   logic [12:0] mr_ff;
   logic [12:0] emr_ff [1:3];
   logic [9:0]  col_ff;
   logic [3:0]  mrd_cnt_ff;
   logic [7:0]  dll_cnt_ff;
   logic [2:0]  burst_cnt_ff;
   logic        on, act, pre, rd, wr, rf, mrs, sref_in, sref_out;
   logic        all_idle, act_ok, rw_ok, mrs_ok, bad, bad_rd;
   logic        cl_ok, any_cmd, dll_rst;

   always_comb begin
      on       = c_ff.cke & cke_prev_ff;
      act      = on & is_op(c_ff, dims_pkg::OP_ACT);
      pre      = on & is_op(c_ff, dims_pkg::OP_PRE);
      rd       = on & is_op(c_ff, dims_pkg::OP_RD);
      wr       = on & is_op(c_ff, dims_pkg::OP_WR);
      rf       = on & is_op(c_ff, dims_pkg::OP_REF);
      mrs      = on & is_op(c_ff, dims_pkg::OP_MRS);
      sref_in  = cke_prev_ff & ~c_ff.cke &
                 is_op(c_ff, dims_pkg::OP_REF);
      sref_out = (st_ff == dims_pkg::DIMS_SREF) & c_ff.cke;
      any_cmd  = act | pre | rd | wr | rf | mrs;
      all_idle = (open_ff == 8'h00);
      for (int i = 0; i < 8; i++) begin
         if (pcnt_ff[i] != 5'h00) all_idle = 1'b0;
      end
      act_ok = act & (st_ff == dims_pkg::DIMS_IDLE)
               & ~open_ff[c_ff.ba] & (pcnt_ff[c_ff.ba] == 5'h00);
      rw_ok  = (rd | wr) & (st_ff == dims_pkg::DIMS_IDLE)
               & open_ff[c_ff.ba];
      // mode writes only with every bank precharged and tRP done
      mrs_ok = mrs & (st_ff == dims_pkg::DIMS_IDLE) & all_idle;
      bad    = (act & ~act_ok) | ((rd | wr) & ~rw_ok)
               | (mrs & ~mrs_ok) | (rf & ~all_idle)
               | (any_cmd & (st_ff != dims_pkg::DIMS_IDLE));
      bad_rd = rd & ~DLL_LOCKED;
      // dll reset request from a legal mode register write
      dll_rst = mrs_ok & (c_ff.ba == dims_pkg::BA_MR)
                & c_ff.addr[dims_pkg::MR_DLLRST];
      // three to five clocks only; half clocks do not exist
      cl_ok  = (mr_ff[6:4] >= 3'h3) && (mr_ff[6:4] <= 3'h5);
   end

   // =====================================================
   // device state: idle, mode register wait, self-refresh
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         st_ff      <= dims_pkg::DIMS_IDLE;
         mrd_cnt_ff <= 4'h0;
      end else begin
         case (st_ff)
            dims_pkg::DIMS_IDLE: begin
               if (mrs_ok) begin
                  st_ff      <= dims_pkg::DIMS_MRD;
                  mrd_cnt_ff <= ctrl_ff.tmrd;
               end else if (sref_in && all_idle) begin
                  st_ff <= dims_pkg::DIMS_SREF;
               end
            end
            dims_pkg::DIMS_MRD: begin
               // tMRD of zero behaves as one clock
               if (mrd_cnt_ff <= 4'h1) begin
                  st_ff <= dims_pkg::DIMS_IDLE;
               end
               mrd_cnt_ff <= mrd_cnt_ff - 4'h1;
            end
            dims_pkg::DIMS_SREF: begin
               if (sref_out) st_ff <= dims_pkg::DIMS_IDLE;
            end
            default: st_ff <= dims_pkg::DIMS_IDLE;
         endcase
      end
   end

   // =====================================================
   // mode and extended registers, loaded only from the bus pins
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         mr_ff  <= '0;
         emr_ff <= '{default: '0};
      end else if (mrs_ok) begin
         case (c_ff.ba)
            dims_pkg::BA_MR:   mr_ff     <= c_ff.addr;
            dims_pkg::BA_EMR1: emr_ff[1] <= c_ff.addr;
            dims_pkg::BA_EMR2: emr_ff[2] <= c_ff.addr;
            dims_pkg::BA_EMR3: emr_ff[3] <= c_ff.addr;
            default: ;
         endcase
      end
   end

   // =====================================================
   // bank open state, row latch and per-bank precharge timers
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         open_ff <= 8'h00;
         row_ff  <= '{default: '0};
         pcnt_ff <= '{default: '0};
         col_ff  <= 10'h000;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (pcnt_ff[i] != 5'h00) pcnt_ff[i] <= pcnt_ff[i] - 5'h01;
            // latest precharge restarts the period for its bank
            if (pre && (c_ff.addr[dims_pkg::AP_BIT] ||
                        c_ff.ba == 3'(i))) begin
               open_ff[i] <= 1'b0;
               pcnt_ff[i] <= ctrl_ff.trp;
            end
         end
         if (act_ok) begin
            open_ff[c_ff.ba] <= 1'b1;
            row_ff[c_ff.ba]  <= c_ff.addr;
         end
         if (rw_ok) begin
            col_ff <= c_ff.addr[9:0];
            // auto precharge closes at issue; burst timing not modelled
            if (c_ff.addr[dims_pkg::AP_BIT]) begin
               open_ff[c_ff.ba] <= 1'b0;
               pcnt_ff[c_ff.ba] <= ctrl_ff.trp;
            end
         end
      end
   end

   // =====================================================
   // burst length counter, in clocks of two beats
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         burst_cnt_ff <= 3'h0;
         BURST_ACTIVE <= 1'b0;
      end else if (rw_ok) begin
         burst_cnt_ff <= (mr_ff[2:0] == dims_pkg::BL_8) ?
                         dims_pkg::BURST8 : dims_pkg::BURST4;
         BURST_ACTIVE <= 1'b1;
      end else begin
         if (burst_cnt_ff != 3'h0) burst_cnt_ff <= burst_cnt_ff - 3'h1;
         BURST_ACTIVE <= burst_cnt_ff > 3'h1;
      end
   end

   // =====================================================
   // dll: reset or self-refresh exit restarts lock count; self-refresh holds lock low
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         dll_cnt_ff <= dims_pkg::DLL_LOCK_CLKS;
         DLL_LOCKED <= 1'b0;
      end else begin
         if (dll_rst || sref_out) begin
            dll_cnt_ff <= dims_pkg::DLL_LOCK_CLKS;
         end else if (dll_cnt_ff != 8'h00) begin
            dll_cnt_ff <= dll_cnt_ff - 8'h01;
         end
         // drop at once on a reset, not one clock after the count reload
         DLL_LOCKED <= ~emr_ff[1][dims_pkg::E1_DLL_DIS]
                       & (st_ff != dims_pkg::DIMS_SREF)
                       & (dll_cnt_ff == 8'h00) & ~sref_in
                       & ~dll_rst;
      end
   end

   // =====================================================
   // axi4-lite slave; one write and one read in flight
   logic        ill_ff, badrd_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        wr_fire, clr_ill, clr_bad;

   always_comb begin
      wr_fire = ~AWREADY & ~WREADY & ~BVALID;
      clr_ill = wr_fire & (awaddr_ff == dims_pkg::OFS_STAT)
                & wstrb_ff[0] & wdata_ff[dims_pkg::ST_ILL];
      clr_bad = wr_fire & (awaddr_ff == dims_pkg::OFS_STAT)
                & wstrb_ff[0] & wdata_ff[dims_pkg::ST_BADRD];
   end

   // address and data taken in either order, response after both
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         AWREADY   <= 1'b1;
         WREADY    <= 1'b1;
         BVALID    <= 1'b0;
         BRESP     <= dims_pkg::RESP_OK;
         awaddr_ff <= 8'h00;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
      end else begin
         if (AWVALID && AWREADY) begin
            AWREADY   <= 1'b0;
            awaddr_ff <= AWADDR;
         end
         if (WVALID && WREADY) begin
            WREADY   <= 1'b0;
            wdata_ff <= WDATA;
            wstrb_ff <= WSTRB;
         end
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= reg_hit(awaddr_ff) ? dims_pkg::RESP_OK
                                          : dims_pkg::RESP_ERR;
         end else if (BVALID && BREADY) begin
            BVALID  <= 1'b0;
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
         end
      end
   end

   // control register steers tRP and tMRD counting
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl_ff <= {dims_pkg::RST_TMRD, dims_pkg::RST_TRP};
      end else if (wr_fire && awaddr_ff == dims_pkg::OFS_CTRL) begin
         if (wstrb_ff[0]) ctrl_ff.trp  <= wdata_ff[4:0];
         if (wstrb_ff[1]) ctrl_ff.tmrd <= wdata_ff[11:8];
      end
   end

   // sticky error flags: a new event beats a same-cycle clear
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ill_ff   <= 1'b0;
         badrd_ff <= 1'b0;
      end else begin
         ill_ff   <= bad | (ill_ff & ~clr_ill);
         badrd_ff <= bad_rd | (badrd_ff & ~clr_bad);
      end
   end

   // read channel, data one clock after the address
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0000_0000;
         RRESP   <= dims_pkg::RESP_OK;
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b1;
         RRESP   <= reg_hit(ARADDR) ? dims_pkg::RESP_OK
                                    : dims_pkg::RESP_ERR;
         case (ARADDR)
            dims_pkg::OFS_MR:   RDATA <= {19'h0, mr_ff};
            dims_pkg::OFS_EMR1: RDATA <= {19'h0, emr_ff[1]};
            dims_pkg::OFS_EMR2: RDATA <= {19'h0, emr_ff[2]};
            dims_pkg::OFS_EMR3: RDATA <= {19'h0, emr_ff[3]};
            dims_pkg::OFS_STAT: RDATA <= {25'h0, ~cl_ok, BURST_ACTIVE,
                                   mr_ff[dims_pkg::MR_TM],
                                   st_ff == dims_pkg::DIMS_SREF,
                                   DLL_LOCKED, badrd_ff, ill_ff};
            dims_pkg::OFS_BANK: RDATA <= {14'h0, col_ff, open_ff};
            dims_pkg::OFS_CTRL: RDATA <= {20'h0, ctrl_ff.tmrd, 3'h0,
                                          ctrl_ff.trp};
            default:            RDATA <= 32'h0000_0000;
         endcase
      end else if (RVALID && RREADY) begin
         RVALID  <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

   // =====================================================
   // assertions
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);

   sequence s_mrs_mr;
      mrs_ok && c_ff.ba == dims_pkg::BA_MR;
   endsequence
   sequence s_dll_reset;
      s_mrs_mr ##0 c_ff.addr[dims_pkg::MR_DLLRST];
   endsequence

   burst_len_a: assert property (rw_ok && mr_ff[2:0] == dims_pkg::BL_8
      |=> burst_cnt_ff == 3'h4 ##1 burst_cnt_ff == 3'h3)
      else $error("burst of eight not counted");
   act_row_a: assert property (act_ok
      |=> open_ff[$past(c_ff.ba)] && row_ff[$past(c_ff.ba)]
          == $past(c_ff.addr))
      else $error("activate did not latch bank row");
   mrs_wait_a: assert property (mrs_ok
      |=> st_ff == dims_pkg::DIMS_MRD
          && ill_ff == ($past(ill_ff) && !$past(clr_ill)))
      else $error("mode write did not enter wait");
   mrd_cmd_a: assert property (
      st_ff == dims_pkg::DIMS_MRD && any_cmd |=> ill_ff)
      else $error("command during mode wait not flagged");
   cas_field_a: assert property (s_mrs_mr
      |=> mr_ff[6:4] == $past(c_ff.addr[6:4])
          && mr_ff[dims_pkg::MR_BT] == $past(c_ff.addr[3]))
      else $error("cas latency field not stored");
   dll_reset_a: assert property (s_dll_reset
      |=> !DLL_LOCKED [*8])
      else $error("dll locked too soon after reset");
   emr1_write_a: assert property (
      mrs_ok && c_ff.ba == dims_pkg::BA_EMR1
      |=> emr_ff[1] == $past(c_ff.addr) && mr_ff == $past(mr_ff))
      else $error("extended register one write wrong");
   sref_dll_a: assert property (st_ff == dims_pkg::DIMS_SREF
      |=> !DLL_LOCKED)
      else $error("dll running in self refresh");
   pre_time_a: assert property (pre && c_ff.addr[dims_pkg::AP_BIT]
      |=> pcnt_ff[0] == $past(ctrl_ff.trp) && !open_ff[0])
      else $error("precharge period not restarted");
   bad_read_a: assert property (rd && !DLL_LOCKED |=> badrd_ff)
      else $error("early read not flagged");
endmodule : dims_top

/* File: bench/dims_ctrl_model.sv */
`timescale 1ns/1ps
// =====================================================
// controller model driving the command pins
module dims_ctrl_model #(
   parameter int PWR_CLKS = 50000 // stable power wait, 200us at 4 ns
) (
   input  wire logic           clk,  // memory clock
   output dims_pkg::dims_cmd_t pins  // command pins to the device
);
   // deselected, CKE low, until the power-up wait ends
   initial pins = {5'h0f, 3'h7, 13'h1fff};

   // one command for one clock, then NOP for gap clocks
   task automatic cmd(input logic [2:0] op, input logic [2:0] ba,
                      input logic [12:0] a, input logic ck, input int gap);
      @(posedge clk);
      pins <= {ck, 1'b0, op, ba, a};
      @(posedge clk);
      // idle address shows the inverse so stale values never pass
      pins <= {ck, 1'b0, 3'h7, ~ba, ~a};
      repeat (gap) @(posedge clk);
   endtask : cmd

   // register write; every field is supplied, nothing kept
   task automatic mrs(input logic [2:0] ba, input logic [12:0] a,
                      input int gap);
      cmd(dims_pkg::OP_MRS, ba, a, 1'b1, gap);
   endtask : mrs

   // =====================================================
   // power-up and init; gaps of 10 cover tMRD and tRP
   task automatic init_seq(input logic [12:0] mr, input logic [12:0] e1);
      repeat (PWR_CLKS) @(posedge clk);
      cmd(3'h7, 3'h0, 13'h0000, 1'b1, 100);
      cmd(dims_pkg::OP_PRE, 3'h0, 13'h0400, 1'b1, 10);
      mrs(dims_pkg::BA_EMR2, 13'h0080, 10);
      mrs(dims_pkg::BA_EMR3, 13'h0000, 10);
      mrs(dims_pkg::BA_EMR1, e1 & 13'h047e, 10);
      mrs(dims_pkg::BA_MR, (mr & 13'h0e7f) | 13'h0100, 10);
      cmd(dims_pkg::OP_PRE, 3'h0, 13'h0400, 1'b1, 10);
      cmd(dims_pkg::OP_REF, 3'h0, 13'h0000, 1'b1, 10);
      cmd(dims_pkg::OP_REF, 3'h0, 13'h0000, 1'b1, 10);
      // long gap keeps OCD and reads 200 clocks past the DLL reset
      mrs(dims_pkg::BA_MR, mr & 13'h0e7f, 200);
      mrs(dims_pkg::BA_EMR1, (e1 & 13'h047e) | 13'h0380, 10);
      mrs(dims_pkg::BA_EMR1, e1 & 13'h047e, 10);
   endtask : init_seq
endmodule : dims_ctrl_model

/* File: bench/dims_top_bench.sv */
`timescale 1ns/1ps
// =====================================================
// bench for the init and mode register block
module dims_top_bench;
   logic                mclk = 1'b0;
   logic                srst = 1'b1;
   logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                arvalid = 1'b0, rready = 1'b0;
   logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]         wdata = 32'h0, rdata, d, t, n;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [1:0]          bresp, rresp, r;
   logic                dll_locked, burst_active;
   logic [12:0]         mr, e1;
   logic [2:0]          b;
   logic [9:0]          col;
   logic [31:0]         seed = 32'h0000004b;
   int                  miscompares = 0;
   int                  comparisons = 0;
   dims_pkg::dims_cmd_t pins;

   dims_top uut (
      .MCLK(mclk), .SRST(srst), .CKE(pins.cke), .CS_N(pins.cs_n),
      .RAS_N(pins.ras_n), .CAS_N(pins.cas_n), .WE_N(pins.we_n),
      .BA(pins.ba), .ADDR(pins.addr), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .DLL_LOCKED(dll_locked), .BURST_ACTIVE(burst_active));

   // shortened power-up wait; the device does not time it
   dims_ctrl_model #(.PWR_CLKS(500)) u_ctl (.clk(mclk), .pins(pins));

   // 250 MHz clock
   initial forever #2 mclk = ~mclk;

   // =====================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic int bl_clks(input logic [12:0] m);
      return (m[2:0] == dims_pkg::BL_8) ? 4 : 2;
   endfunction : bl_clks

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // axi write: both channels offered at once, each held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   // axi read; data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic stb(input int i, input logic e);
      rd(dims_pkg::OFS_STAT);
      chk({31'h0, d[i]}, {31'h0, e});
   endtask : stb

   task automatic cm(input logic [2:0] op, input logic [2:0] ba,
                     input logic [12:0] a, input int gap);
      u_ctl.cmd(op, ba, a, 1'b1, gap);
   endtask : cm

   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   // watchdog sized well above the ~1400 clocks the run needs
   initial begin
      repeat (10000) @(posedge mclk);
      miscompares++;
      stop_test();
   end

   // =====================================================
   // main sequence
   initial begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      // reset values and refused addresses
      rd(dims_pkg::OFS_CTRL);
      chk(d, 32'h00000205);
      rd(8'h1c);
      chk({30'h0, r}, {30'h0, dims_pkg::RESP_ERR});
      wr(8'h20, 32'h0);
      chk({30'h0, r}, {30'h0, dims_pkg::RESP_ERR});
      wr(dims_pkg::OFS_CTRL, 32'h00000305);
      rd(dims_pkg::OFS_CTRL);
      chk(d, 32'h00000305);
      // full init with random operating values
      t = rnd();
      mr = {1'b0, t[2:0], 2'b00, 3'h3 + {1'b0, t[4:3] % 2'h3}, t[5],
            t[6] ? dims_pkg::BL_8 : 3'h2};
      e1 = t[23:11] & 13'h047e;
      u_ctl.init_seq(mr, e1);
      rd(dims_pkg::OFS_MR);
      chk(d, {19'h0, mr});
      rd(dims_pkg::OFS_EMR1);
      chk(d, {19'h0, e1});
      rd(dims_pkg::OFS_EMR2);
      chk(d, 32'h00000080);
      stb(dims_pkg::ST_ILL, 1'b0);
      chk({31'h0, dll_locked}, 32'h1);
      // read then write with auto precharge, at BL 4 then BL 8
      for (int k = 0; k < 2; k++) begin
         t = rnd();
         b = t[2:0];
         col = t[12:3];
         mr[2:0] = (k != 0) ? dims_pkg::BL_8 : 3'h2;
         cm(dims_pkg::OP_MRS, dims_pkg::BA_MR, mr, 10);
         cm(dims_pkg::OP_ACT, b, t[25:13], 10);
         rd(dims_pkg::OFS_BANK);
         chk(d & 32'hff, 32'h1 << b);
         u_ctl.cmd((k != 0) ? dims_pkg::OP_WR : dims_pkg::OP_RD, b,
                   {3'h1, col}, 1'b1, 0);
         n = 0;
         repeat (12) begin
            @(posedge mclk);
            n = n + burst_active;
         end
         chk(n, bl_clks(mr));
         rd(dims_pkg::OFS_BANK);
         chk(d, {14'h0, col, 8'h00});
      end
      stb(dims_pkg::ST_BADRD, 1'b0);
      // activate inside the precharge period is refused
      cm(dims_pkg::OP_ACT, 3'h1, 13'h0, 10);
      u_ctl.cmd(dims_pkg::OP_PRE, 3'h1, 13'h0, 1'b1, 0);
      cm(dims_pkg::OP_ACT, 3'h1, 13'h0, 10);
      stb(dims_pkg::ST_ILL, 1'b1);
      wr(dims_pkg::OFS_STAT, 32'h3);
      stb(dims_pkg::ST_ILL, 1'b0);
      cm(dims_pkg::OP_ACT, 3'h1, 13'h0, 10);
      stb(dims_pkg::ST_ILL, 1'b0);
      // mode write with a bank open is refused and leaves the register
      cm(dims_pkg::OP_MRS, dims_pkg::BA_MR, 13'h0000, 10);
      stb(dims_pkg::ST_ILL, 1'b1);
      rd(dims_pkg::OFS_MR);
      chk(d, {19'h0, mr});
      cm(dims_pkg::OP_PRE, 3'h0, 13'h0400, 10);
      // test mode bit is flagged while set
      cm(dims_pkg::OP_MRS, dims_pkg::BA_MR, mr | 13'h0080, 10);
      stb(4, 1'b1);
      cm(dims_pkg::OP_MRS, dims_pkg::BA_MR, mr, 10);
      stb(4, 1'b0);
      // self-refresh drops the lock; an early read is flagged
      u_ctl.cmd(dims_pkg::OP_REF, 3'h0, 13'h0, 1'b0, 10);
      stb(3, 1'b1);
      chk({31'h0, dll_locked}, 32'h0);
      u_ctl.cmd(3'h7, 3'h0, 13'h0, 1'b1, 10);
      cm(dims_pkg::OP_ACT, 3'h2, 13'h0, 10);
      cm(dims_pkg::OP_RD, 3'h2, 13'h0, 10);
      stb(dims_pkg::ST_BADRD, 1'b1);
      chk({31'h0, dll_locked}, 32'h0);
      repeat (200) @(posedge mclk);
      chk({31'h0, dll_locked}, 32'h1);
      stop_test();
   end
endmodule : dims_top_bench
